// ==== core/pipe_cfg_pkg.sv ====
/*
 Constants for the per-pipe configuration and control block: register
 offsets, field positions, reset values and encodings.
 Assumes a 16-bit register port with byte addresses as printed.
*/
package pipe_cfg_pkg;
    localparam int ADDR_W = 20;
    localparam logic [19:0] OFF_WINDOW_SEL = 20'hF0464;
    localparam logic [19:0] OFF_PIPE_CFG = 20'hF0468;
    localparam logic [19:0] OFF_MAX_PACKET = 20'hF046C;
    localparam logic [19:0] OFF_CYCLE_CTRL = 20'hF046E;
    localparam logic [19:0] OFF_PIPE_FOUR = 20'hF0476;
    localparam logic [19:0] OFF_PIPE_FIVE = 20'hF0478;
    localparam logic [19:0] OFF_PIPE_SIX = 20'hF047A;
    localparam logic [19:0] OFF_PIPE_SEVEN = 20'hF047C;
    localparam logic [15:0] RESET_VALUE = 16'h0000;
    // Per-register field masks
    localparam logic [15:0] CFG_MASK = 16'hC69F;
    localparam logic [15:0] MAXP_MASK = 16'h71FF;
    localparam logic [15:0] PERI_MASK = 16'h0007;
    localparam logic [15:0] CTRL_MASK = 16'h0603;
    localparam int CFG_DIR_BIT = 4;
    localparam int CTRL_ACLR_BIT = 9;
    localparam int CTRL_BUSY_BIT = 5;
    localparam int MAXP_SEL_LSB = 12;
    localparam logic [1:0] RESP_NAK = 2'h0;
    localparam logic [1:0] RESP_BUF = 2'h1;
    localparam logic [3:0] FIRST_PIPE = 4'h4;
    localparam int NUM_PIPES = 4;
    localparam logic [2:0] MAX_DEV_SEL = 3'h5;
endpackage

// ==== core/usb_pipe_config_control.sv ====
/*
 Per-pipe configuration registers for pipes 4 to 7, reached through a
 window select, plus per-pipe response, busy and auto buffer clear.
 Assumes a transaction engine that asks for a pipe with a start pulse
 and reports its end with a done pulse; software keeps the NAK rules.
*/
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
module usb_pipe_config_control (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Register port
    input wire logic [19:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    // Transaction engine side
    input wire logic [1:0] txn_pipe_in,
    input wire logic txn_start_in,
    input wire logic txn_done_in,
    output logic txn_grant_out,
    output logic txn_transmit_out,
    output logic [3:0] txn_endpoint_out,
    output logic [2:0] txn_device_out,
    output logic [8:0] txn_max_packet_out,
    output logic [2:0] txn_interval_out,
    output logic [3:0] fifo_clear_out,
    output logic [3:0] interval_restart_out
);
    logic [3:0] window_sel;
    logic [15:0] cfg [pipe_cfg_pkg::NUM_PIPES];
    logic [15:0] maxp [pipe_cfg_pkg::NUM_PIPES];
    logic [15:0] peri [pipe_cfg_pkg::NUM_PIPES];
    logic [15:0] ctrl [pipe_cfg_pkg::NUM_PIPES];
    logic [3:0] busy;
    logic [3:0] clear_armed;

    function automatic logic [2:0] ctrl_index(input logic [19:0] a);
        logic [2:0] r;
        r = 3'h0;
        case (a)
            pipe_cfg_pkg::OFF_PIPE_FOUR: r = 3'h4;
            pipe_cfg_pkg::OFF_PIPE_FIVE: r = 3'h5;
            pipe_cfg_pkg::OFF_PIPE_SIX: r = 3'h6;
            pipe_cfg_pkg::OFF_PIPE_SEVEN: r = 3'h7;
            default: r = 3'h0;
        endcase
        return r;
    endfunction

    wire logic win_valid = (window_sel >= pipe_cfg_pkg::FIRST_PIPE) && (window_sel <= 4'h7);
    wire logic [1:0] win_idx = window_sel[1:0];
    wire logic [2:0] ctrl_hit = ctrl_index(addr_in);
    wire logic ctrl_sel = ctrl_hit[2];
    wire logic [1:0] ctrl_idx = ctrl_hit[1:0];
    wire logic wr_sel = wr_in && (addr_in == pipe_cfg_pkg::OFF_WINDOW_SEL);
    wire logic wr_cfg = wr_in && win_valid && (addr_in == pipe_cfg_pkg::OFF_PIPE_CFG);
    wire logic wr_maxp = wr_in && win_valid && (addr_in == pipe_cfg_pkg::OFF_MAX_PACKET);
    wire logic wr_peri = wr_in && win_valid && (addr_in == pipe_cfg_pkg::OFF_CYCLE_CTRL);
    wire logic wr_ctrl = wr_in && ctrl_sel;
    wire logic [1:0] eng_idx = txn_pipe_in;
    wire logic eng_used = (cfg[eng_idx][3:0] != 4'h0);
    wire logic eng_buf = (ctrl[eng_idx][1:0] == pipe_cfg_pkg::RESP_BUF);
    // only codes 0 to 5 are valid targets
    wire logic eng_dev_ok = (maxp[eng_idx][14:12] <= pipe_cfg_pkg::MAX_DEV_SEL);
    wire logic accept = txn_start_in && eng_used && eng_buf && eng_dev_ok && !busy[eng_idx];
    logic [15:0] next_rdata;

    always_comb begin
        next_rdata = 16'h0000;
        if (addr_in == pipe_cfg_pkg::OFF_WINDOW_SEL) begin
            next_rdata = {12'h000, window_sel};
        end else if (win_valid && addr_in == pipe_cfg_pkg::OFF_PIPE_CFG) begin
            next_rdata = cfg[win_idx] & pipe_cfg_pkg::CFG_MASK;
        end else if (win_valid && addr_in == pipe_cfg_pkg::OFF_MAX_PACKET) begin
            next_rdata = maxp[win_idx] & pipe_cfg_pkg::MAXP_MASK;
        end else if (win_valid && addr_in == pipe_cfg_pkg::OFF_CYCLE_CTRL) begin
            next_rdata = peri[win_idx] & pipe_cfg_pkg::PERI_MASK;
        end else if (ctrl_sel) begin
            next_rdata = (ctrl[ctrl_idx] & pipe_cfg_pkg::CTRL_MASK)
                | {10'h000, busy[ctrl_idx], 5'h00};
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= pipe_cfg_pkg::RESET_VALUE;
        end else begin
            rdata_out <= rd_in ? next_rdata : pipe_cfg_pkg::RESET_VALUE;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            window_sel <= 4'h0;
        end else if (wr_sel) begin
            window_sel <= wdata_in[3:0];
        end
    end

    genvar p;
    generate
        for (p = 0; p < pipe_cfg_pkg::NUM_PIPES; p++) begin : g_pipe
            wire logic win_here = (win_idx == 2'(p));
            wire logic ctrl_here = wr_ctrl && (ctrl_idx == 2'(p));
            wire logic start_here = accept && (eng_idx == 2'(p));
            wire logic done_here = txn_done_in && busy[p] && (eng_idx == 2'(p));
            // falling edge of the clear bit fires the erase
            wire logic clear_fire = ctrl_here && clear_armed[p] && !wdata_in[pipe_cfg_pkg::CTRL_ACLR_BIT];

            // Software writes are plain stores
            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    cfg[p] <= pipe_cfg_pkg::RESET_VALUE;
                    maxp[p] <= pipe_cfg_pkg::RESET_VALUE;
                    peri[p] <= pipe_cfg_pkg::RESET_VALUE;
                end else begin
                    if (wr_cfg && win_here) cfg[p] <= wdata_in & pipe_cfg_pkg::CFG_MASK;
                    if (wr_maxp && win_here) maxp[p] <= wdata_in & pipe_cfg_pkg::MAXP_MASK;
                    if (wr_peri && win_here) peri[p] <= wdata_in & pipe_cfg_pkg::PERI_MASK;
                end
            end

            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    ctrl[p] <= pipe_cfg_pkg::RESET_VALUE;
                end else if (ctrl_here) begin
                    ctrl[p] <= wdata_in & pipe_cfg_pkg::CTRL_MASK;
                end
            end

            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    busy[p] <= 1'b0;
                end else if (start_here) begin
                    busy[p] <= 1'b1;
                end else if (done_here) begin
                    busy[p] <= 1'b0;
                end
            end

            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    clear_armed[p] <= 1'b0;
                    fifo_clear_out[p] <= 1'b0;
                    interval_restart_out[p] <= 1'b0;
                end else begin
                    if (ctrl_here) clear_armed[p] <= wdata_in[pipe_cfg_pkg::CTRL_ACLR_BIT];
                    fifo_clear_out[p] <= clear_fire;
                    // setting the clear bit restarts the interval timer
                    interval_restart_out[p] <= ctrl_here && wdata_in[pipe_cfg_pkg::CTRL_ACLR_BIT]
                        && !clear_armed[p];
                end
            end
        end
    endgenerate

    // fields latched only when a transaction is granted
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            txn_grant_out <= 1'b0;
            txn_transmit_out <= 1'b0;
            txn_endpoint_out <= 4'h0;
            txn_device_out <= 3'h0;
            txn_max_packet_out <= 9'h000;
            txn_interval_out <= 3'h0;
        end else begin
            txn_grant_out <= accept;
            if (accept) begin
                // direction bit picks transmit or receive
                txn_transmit_out <= cfg[eng_idx][pipe_cfg_pkg::CFG_DIR_BIT];
                txn_endpoint_out <= cfg[eng_idx][3:0];
                txn_device_out <= maxp[eng_idx][14:12];
                txn_max_packet_out <= maxp[eng_idx][8:0];
                txn_interval_out <= peri[eng_idx][2:0];
            end
        end
    end

    a_busy_after_start: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        accept |=> busy[$past(eng_idx)]) else $error("Busy not set after start");
    a_dir_forwarded: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        accept |=> txn_transmit_out == $past(cfg[eng_idx][pipe_cfg_pkg::CFG_DIR_BIT]))
        else $error("Direction not forwarded");
    a_unused_blocked: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        txn_grant_out |-> txn_endpoint_out != 4'h0) else $error("Unused pipe granted");
    a_nak_blocks: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        txn_start_in && ctrl[eng_idx][1:0] != pipe_cfg_pkg::RESP_BUF |=> !txn_grant_out)
        else $error("Grant without buffer response");
    a_dev_range: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        txn_grant_out |-> txn_device_out <= pipe_cfg_pkg::MAX_DEV_SEL) else $error("Bad device select");
    a_read_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rd_in && addr_in == pipe_cfg_pkg::OFF_WINDOW_SEL |=> rdata_out[15:4] == 12'h000)
        else $error("Unassigned bits not zero");
    // clear pulse is one cycle on any pipe
    a_clear_pulse: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        fifo_clear_out != 4'h0 |=> (fifo_clear_out & $past(fifo_clear_out)) == 4'h0)
        else $error("Clear pulse too long");
    // falling clear bit erases that pipe
    a_clear_after_fall: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_ctrl && clear_armed[ctrl_idx] && !wdata_in[pipe_cfg_pkg::CTRL_ACLR_BIT]
        |=> fifo_clear_out[$past(ctrl_idx)])
        else $error("Clear bit fall did not erase");
    // rising clear bit restarts the timer
    a_restart_rise: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_ctrl && wdata_in[pipe_cfg_pkg::CTRL_ACLR_BIT] && !clear_armed[ctrl_idx]
        |=> interval_restart_out[$past(ctrl_idx)])
        else $error("Interval timer not restarted");
    a_done_clears: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        txn_done_in && busy[eng_idx] |=> !busy[$past(eng_idx)])
        else $error("Busy not cleared after done");
    // a busy pipe takes no second start
    a_busy_blocks: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        txn_start_in && busy[eng_idx] |=> !txn_grant_out)
        else $error("Start granted on busy pipe");
    // read data is zero outside the answer cycle
    a_rdata_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !rd_in |=> rdata_out == 16'h0000) else $error("Read data outside answer");
    // Every decoded address, for the unmapped check below
    wire logic addr_mapped = (addr_in == pipe_cfg_pkg::OFF_WINDOW_SEL)
        || (addr_in == pipe_cfg_pkg::OFF_PIPE_CFG)
        || (addr_in == pipe_cfg_pkg::OFF_MAX_PACKET)
        || (addr_in == pipe_cfg_pkg::OFF_CYCLE_CTRL)
        || ctrl_sel;
    a_unmapped_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rd_in && !addr_mapped |=> rdata_out == 16'h0000)
        else $error("Unmapped address not zero");
    a_cfg_masked: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_cfg |=> cfg[$past(win_idx)] == ($past(wdata_in) & pipe_cfg_pkg::CFG_MASK))
        else $error("Config word stored wrongly");
    // window select takes the written code
    a_window_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_sel |=> window_sel == $past(wdata_in[3:0]))
        else $error("Window select not stored");
    a_window_none: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rd_in && !win_valid && addr_in == pipe_cfg_pkg::OFF_PIPE_CFG |=> rdata_out == 16'h0000)
        else $error("Config visible without window");
    a_fields_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !accept |=> $stable(txn_endpoint_out)) else $error("Fields changed mid transaction");
    // packet size and target hold too
    a_size_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !accept |=> $stable(txn_max_packet_out) && $stable(txn_device_out))
        else $error("Size or target changed mid transaction");

    c_grant: cover property (@(posedge clk_in) disable iff (!rst_n_in) txn_grant_out);
    c_clear: cover property (@(posedge clk_in) disable iff (!rst_n_in) |fifo_clear_out);
    c_restart: cover property (@(posedge clk_in) disable iff (!rst_n_in) |interval_restart_out);
    c_done: cover property (@(posedge clk_in) disable iff (!rst_n_in) txn_done_in && |busy);
    // Refusals matter as much as grants
    c_refused: cover property (@(posedge clk_in) disable iff (!rst_n_in) txn_start_in && !accept);
endmodule // usb_pipe_config_control

// ==== testbench/txn_engine_model.sv ====
/*
 Behavioural transaction engine that faces the pipe block.
 Assumes the bench pulses go_in for one cycle and waits out each transfer.
*/
`timescale 1ns/100ps
module txn_engine_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Bench commands
    input wire logic go_in,
    input wire logic [1:0] go_pipe_in,
    input wire logic [3:0] hold_in,
    // Block side
    input wire logic grant_in,
    output logic [1:0] txn_pipe_out,
    output logic txn_start_out,
    output logic txn_done_out
);
    logic waiting;
    logic [4:0] count;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            txn_pipe_out <= 2'h0;
            txn_start_out <= 1'b0;
            txn_done_out <= 1'b0;
            waiting <= 1'b0;
            count <= 5'h00;
        end else begin
            txn_start_out <= go_in;
            txn_done_out <= 1'b0;
            waiting <= txn_start_out;
            if (go_in) begin
                txn_pipe_out <= go_pipe_in;
            end
            if (waiting && grant_in) begin
                count <= {1'b0, hold_in} + 5'h01;
            end else if (count != 5'h00) begin
                count <= count - 5'h01;
                txn_done_out <= (count == 5'h01);
            end
        end
    end
endmodule // txn_engine_model

// ==== testbench/tb_top.sv ====
/*
 Register-level bench for the pipe configuration block.
 Assumes the engine model sits on the transaction side.
*/
`timescale 1ns/100ps
module tb_top;
    logic clk_in, rst_n_in, wr_in, rd_in, go, txn_start_in, txn_done_in, txn_grant_out, txn_transmit_out;
    logic [19:0] addr_in;
    logic [15:0] wdata_in, rdata_out, ngrant;
    logic [1:0] go_pipe, txn_pipe_in;
    logic [3:0] txn_endpoint_out, fifo_clear_out, interval_restart_out;
    logic [2:0] txn_device_out, txn_interval_out;
    logic [8:0] txn_max_packet_out;
    int n_mismatch, check_count;
    usb_pipe_config_control i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .txn_pipe_in(txn_pipe_in), .txn_start_in(txn_start_in),
        .txn_done_in(txn_done_in), .txn_grant_out(txn_grant_out), .txn_transmit_out(txn_transmit_out),
        .txn_endpoint_out(txn_endpoint_out), .txn_device_out(txn_device_out), .txn_max_packet_out(txn_max_packet_out),
        .txn_interval_out(txn_interval_out), .fifo_clear_out(fifo_clear_out), .interval_restart_out(interval_restart_out));
    txn_engine_model i_engine (.clk_in(clk_in), .rst_n_in(rst_n_in), .go_in(go), .go_pipe_in(go_pipe),
        .hold_in(4'h8), .grant_in(txn_grant_out), .txn_pipe_out(txn_pipe_in), .txn_start_out(txn_start_in),
        .txn_done_out(txn_done_in));
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        if (txn_grant_out === 1'b1) begin
            ngrant <= ngrant + 16'h0001;
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [19:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [19:0] a, input logic [15:0] e);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        @(negedge clk_in);
        chk(rdata_out, e);
    endtask
    // One engine request, then time for the grant to land
    task automatic run(input logic [1:0] p);
        @(posedge clk_in);
        go <= 1'b1;
        go_pipe <= p;
        @(posedge clk_in);
        go <= 1'b0;
        repeat (3) @(posedge clk_in);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        n_mismatch++;
        results();
    end
    initial begin
        {rst_n_in, wr_in, rd_in, go, go_pipe, addr_in, wdata_in, ngrant} = '0;
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(pipe_cfg_pkg::OFF_PIPE_FOUR, 16'h0000);
        rd(pipe_cfg_pkg::OFF_PIPE_FIVE, 16'h0000);
        rd(pipe_cfg_pkg::OFF_WINDOW_SEL, 16'h0000);
        wr(pipe_cfg_pkg::OFF_WINDOW_SEL, 16'h0004);
        rd(pipe_cfg_pkg::OFF_MAX_PACKET, 16'h0000);
        rd(pipe_cfg_pkg::OFF_CYCLE_CTRL, 16'h0000);
        wr(pipe_cfg_pkg::OFF_PIPE_CFG, 16'hFFFF);
        rd(pipe_cfg_pkg::OFF_PIPE_CFG, pipe_cfg_pkg::CFG_MASK);
        wr(pipe_cfg_pkg::OFF_MAX_PACKET, 16'hFFFF);
        rd(pipe_cfg_pkg::OFF_MAX_PACKET, pipe_cfg_pkg::MAXP_MASK);
        wr(pipe_cfg_pkg::OFF_CYCLE_CTRL, 16'hFFFF);
        rd(pipe_cfg_pkg::OFF_CYCLE_CTRL, pipe_cfg_pkg::PERI_MASK);
        wr(pipe_cfg_pkg::OFF_WINDOW_SEL, 16'h0005);
        rd(pipe_cfg_pkg::OFF_PIPE_CFG, 16'h0000);
        wr(pipe_cfg_pkg::OFF_WINDOW_SEL, 16'h0000);
        wr(pipe_cfg_pkg::OFF_PIPE_CFG, 16'h0013);
        rd(pipe_cfg_pkg::OFF_PIPE_CFG, 16'h0000);
        rd(20'hF0400, 16'h0000);
        $display("test registers done");
        wr(pipe_cfg_pkg::OFF_WINDOW_SEL, 16'h0004);
        wr(pipe_cfg_pkg::OFF_PIPE_CFG, 16'h0013);
        wr(pipe_cfg_pkg::OFF_MAX_PACKET, 16'h2040);
        wr(pipe_cfg_pkg::OFF_CYCLE_CTRL, 16'h0003);
        wr(pipe_cfg_pkg::OFF_PIPE_FOUR, 16'h0001);
        run(2'h0);
        chk(ngrant, 16'h0001);
        chk({8'h00, txn_transmit_out, txn_endpoint_out, txn_device_out}, 16'h009A);
        chk({7'h00, txn_max_packet_out}, 16'h0040);
        chk({13'h0000, txn_interval_out}, 16'h0003);
        rd(pipe_cfg_pkg::OFF_PIPE_FOUR, 16'h0021);
        repeat (20) @(posedge clk_in);
        rd(pipe_cfg_pkg::OFF_PIPE_FOUR, 16'h0001);
        $display("test grant done");
        // Unused endpoint, bad device, NAK, stall
        for (int i = 0; i < 4; i++) begin
            wr(pipe_cfg_pkg::OFF_PIPE_CFG, i == 0 ? 16'h0010 : 16'h0003);
            wr(pipe_cfg_pkg::OFF_MAX_PACKET, i == 1 ? 16'h6040 : 16'h5040);
            wr(pipe_cfg_pkg::OFF_PIPE_FOUR, i == 2 ? 16'h0000 : (i == 3 ? 16'h0002 : 16'h0001));
            run(2'h0);
            chk(ngrant, 16'h0001);
        end
        wr(pipe_cfg_pkg::OFF_PIPE_FOUR, 16'h0001);
        run(2'h0);
        chk({8'h00, txn_transmit_out, txn_endpoint_out, txn_device_out}, 16'h001D);
        repeat (20) @(posedge clk_in);
        wr(pipe_cfg_pkg::OFF_WINDOW_SEL, 16'h0007);
        wr(pipe_cfg_pkg::OFF_PIPE_CFG, 16'h0015);
        wr(pipe_cfg_pkg::OFF_MAX_PACKET, 16'h1008);
        wr(pipe_cfg_pkg::OFF_PIPE_SEVEN, 16'h0001);
        run(2'h3);
        chk(ngrant, 16'h0003);
        chk({8'h00, txn_transmit_out, txn_endpoint_out, txn_device_out}, 16'h00A9);
        $display("test refusals done");
        wr(pipe_cfg_pkg::OFF_PIPE_FIVE, 16'hFFFF);
        @(negedge clk_in);
        chk({12'h000, interval_restart_out}, 16'h0002);
        rd(pipe_cfg_pkg::OFF_PIPE_FIVE, pipe_cfg_pkg::CTRL_MASK);
        wr(pipe_cfg_pkg::OFF_PIPE_FIVE, 16'h0000);
        @(negedge clk_in);
        chk({12'h000, fifo_clear_out}, 16'h0002);
        $display("test auto clear done");
        repeat (20) @(posedge clk_in);
        results();
    end
endmodule // tb_top
